// ===== bench/awsp_cmd_test.sv
`timescale 1ns/100ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_mismatch++; \
    $display("Error at %0t: got %h expected %h", $time, a, b); end end
module awsp_cmd_test;
    logic ref_clk_in = 1'b0, rst_b_in = 1'b0, cmd_valid_in = 1'b0, slow = 1'b0;
    logic xfer_done_in, busy_out, intrq_out, xfer_req_out, xfer_buf_out, xfer_verify_out;
    logic standby_out, smart_en_out, autosave_out, smart_req_out, offline_out;
    logic [47:0] xfer_lba_out, max_lba_out, first_lba;
    logic [15:0] smart_evt_out;
    logic [7:0]  smart_kind_out, smart_sel_out, mult_out;
    logic        v_seen, b_seen;
    awsp_pkg::awsp_taskfile_t cmd_in = '0;
    awsp_pkg::awsp_status_t   status_out;
    int n_mismatch = 0, n_compared = 0, cyc = 0, n_irq, n_sec, n_req, n_off;
    logic [7:0] sends [3] = '{awsp_pkg::SF_READ_DATA, awsp_pkg::SF_READ_LOG,
                              awsp_pkg::SF_STATUS};
    always #20 ref_clk_in = ~ref_clk_in;
    awsp_cmd dut_u (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .cmd_valid_in(cmd_valid_in),
        .cmd_in(cmd_in), .xfer_done_in(xfer_done_in), .busy_out(busy_out),
        .intrq_out(intrq_out), .status_out(status_out), .xfer_req_out(xfer_req_out),
        .xfer_lba_out(xfer_lba_out), .xfer_buf_out(xfer_buf_out),
        .xfer_verify_out(xfer_verify_out), .standby_out(standby_out),
        .smart_en_out(smart_en_out), .autosave_out(autosave_out),
        .smart_evt_out(smart_evt_out), .smart_req_out(smart_req_out),
        .smart_kind_out(smart_kind_out), .smart_sel_out(smart_sel_out),
        .offline_out(offline_out), .mult_out(mult_out), .max_lba_out(max_lba_out));
    awsp_xfer_model host_u (.ref_clk_in(ref_clk_in), .xfer_req_in(xfer_req_out),
        .slow_in(slow), .xfer_done_out(xfer_done_in));
    ////////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic close_out;
        $display("Compared %0d, mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : close_out
    // Edge monitor: pulses, sectors, first address; hang limit
    always @(posedge ref_clk_in) begin
        cyc++;
        n_irq += intrq_out;
        n_req += smart_req_out;
        n_off += offline_out;
        if (xfer_req_out === 1'b1) begin
            v_seen |= xfer_verify_out;
            b_seen |= xfer_buf_out;
        end
        if (xfer_req_out && xfer_done_in) begin
            if (n_sec == 0) first_lba = xfer_lba_out;
            n_sec++;
        end
        if (cyc == 95000) begin
            n_mismatch++;
            close_out();
        end
    end
    // One command: strobe, wait for idle, let the final pulse be counted
    task automatic run(input logic [7:0] op, input logic [7:0] fe, input logic [15:0] cnt,
                       input logic [47:0] lba);
        int t;
        {n_irq, n_sec, n_req, n_off, v_seen, b_seen} = '0;
        cmd_in = {op, fe, cnt, lba};
        cmd_valid_in = 1'b1;
        @(posedge ref_clk_in);
        #1 cmd_valid_in = 1'b0;
        t = 0;
        while (busy_out === 1'b1 && t < 70000) begin
            @(posedge ref_clk_in);
            #1 t++;
        end
        @(posedge ref_clk_in);
        #1;
    endtask : run
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge ref_clk_in);
        #1 rst_b_in = 1'b1;
        `CHK(mult_out, awsp_pkg::MULT_RST)
        `CHK(max_lba_out, awsp_pkg::MAX_LBA_RST)
        run(8'h30, 8'h00, 16'h0002, 48'h5);
        `CHK({n_sec, n_irq, first_lba}, {32'h2, 32'h2, 48'h5})
        `CHK(smart_evt_out, 16'h0)
        run(8'hb0, 8'hd0, 16'h0, 48'h0);
        `CHK({status_out, n_req}, {3'h6, 32'h0})
        run(8'hb0, 8'hd8, 16'h0, 48'h0);
        `CHK(smart_en_out, 1'b1)
        run(8'h30, 8'h00, 16'h0003, 48'h0);
        `CHK(smart_evt_out, 16'h3)
        for (int i = 0; i < 3; i++) begin
            run(8'hb0, sends[i], 16'h0, {40'h0, sends[i] ^ 8'h5a});
            `CHK({n_req, smart_kind_out, smart_sel_out},
                 {32'h1, sends[i], sends[i] ^ 8'h5a})
        end
        run(8'hb0, 8'hd2, 16'h0001, 48'h0);
        `CHK(autosave_out, 1'b1)
        run(8'hb0, 8'hd4, 16'h0, 48'h81);
        `CHK({n_off, smart_sel_out, status_out}, {32'h1, 8'h81, 3'h0})
        run(8'hb0, 8'h11, 16'h0, 48'h0);
        `CHK({status_out, n_irq}, {3'h6, 32'h1})
        run(8'h00, 8'h00, 16'h0, 48'h0);
        `CHK(status_out, 3'h6)
        run(8'hb0, 8'hd9, 16'h0, 48'h0);
        `CHK({smart_en_out, smart_evt_out}, {1'b0, 16'h0})
        run(8'hb0, 8'hd9, 16'h0, 48'h0);
        `CHK(status_out, 3'h6)
        $display("Test smart done");
        run(8'he2, 8'h00, 16'h0, 48'h0);
        `CHK({standby_out, n_irq}, {1'b1, 32'h1})
        run(8'he0, 8'h00, 16'h0, 48'h0);
        `CHK({standby_out, n_irq, busy_out}, {1'b1, 32'h1, 1'b0})
        slow = 1'b1;
        run(8'hc6, 8'h00, 16'h0002, 48'h0);
        `CHK(mult_out, 8'h02)
        run(8'hc5, 8'h00, 16'h0004, 48'ha);
        `CHK({n_sec, n_irq, first_lba}, {32'h4, 32'h2, 48'ha})
        run(8'h39, 8'h00, 16'h0003, 48'h20);
        `CHK({n_sec, n_irq, first_lba}, {32'h3, 32'h2, 48'h20})
        run(8'h34, 8'h00, 16'h0002, 48'h0);
        `CHK({n_sec, n_irq}, {32'h2, 32'h2})
        run(8'h3c, 8'h00, 16'h0001, 48'h7);
        `CHK({v_seen, n_irq}, {1'b1, 32'h1})
        run(8'he8, 8'h00, 16'h0, 48'h0);
        `CHK({b_seen, n_sec}, {1'b1, 32'h1})
        run(8'h30, 8'h00, 16'h0000, 48'h0);
        `CHK({n_sec, n_irq}, {32'h100, 32'h100})
        slow = 1'b0;
        run(8'hca, 8'h00, 16'h0000, 48'h0);
        `CHK({n_sec, n_irq}, {32'h100, 32'h1})
        run(8'h35, 8'h00, 16'h0000, 48'h0);
        `CHK({n_sec, n_irq}, {32'h10000, 32'h1})
        $display("Test write done");
        run(8'hf9, 8'h00, 16'h0, 48'h64);
        `CHK(max_lba_out, 48'h64)
        run(8'h30, 8'h00, 16'h0002, 48'h63);
        `CHK({status_out, n_sec, n_irq}, {3'h0, 32'h2, 32'h2})
        run(8'h30, 8'h00, 16'h0002, 48'h64);
        `CHK({status_out, n_sec, n_irq}, {3'h5, 32'h0, 32'h1})
        $display("Test max address done");
        close_out();
    end
endmodule : awsp_cmd_test

// ===== bench/awsp_xfer_model.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Far-side sector mover: answers each request at once or every other cycle
module awsp_xfer_model (
    input  wire logic ref_clk_in,   // Clock
    input  wire logic xfer_req_in,  // Sector wanted
    input  wire logic slow_in,      // Stall alternate cycles
    output logic      xfer_done_out // Sector moved
);
    logic ph_reg = 1'b0; // Stall phase
    initial xfer_done_out = 1'b0;
    // Done changes just after the edge, only while a sector is wanted
    always @(posedge ref_clk_in) begin
        #1;
        ph_reg = ~ph_reg;
        xfer_done_out = xfer_req_in & (~slow_in | ph_reg);
    end
endmodule : awsp_xfer_model

// ===== include/awsp_pkg.sv
package awsp_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Opcodes
    localparam logic [7:0] OP_SMART        = 8'hb0; // SMART family
    localparam logic [7:0] OP_STANDBY      = 8'he2; // Standby
    localparam logic [7:0] OP_STANDBY_IMM  = 8'he0; // Standby immediate
    localparam logic [7:0] OP_WR_BUFFER    = 8'he8; // Sector buffer write
    localparam logic [7:0] OP_WR_DMA_A     = 8'hca; // DMA write, 28-bit
    localparam logic [7:0] OP_WR_DMA_B     = 8'hcb; // DMA write, 28-bit
    localparam logic [7:0] OP_WR_DMA_EXT   = 8'h35; // DMA write, extended
    localparam logic [7:0] OP_WR_PIO       = 8'h30; // PIO write, 28-bit
    localparam logic [7:0] OP_WR_PIO_EXT   = 8'h34; // PIO write, extended
    localparam logic [7:0] OP_WR_NOERASE   = 8'h38; // Write without erase
    localparam logic [7:0] OP_WR_MULT      = 8'hc5; // Multiple write, 28-bit
    localparam logic [7:0] OP_WR_MULT_EXT  = 8'h39; // Multiple write, extended
    localparam logic [7:0] OP_WR_VERIFY    = 8'h3c; // Write then verify
    localparam logic [7:0] OP_SET_MULT     = 8'hc6; // Set block count
    localparam logic [7:0] OP_SET_MAX      = 8'hf9; // Set max address
    localparam logic [7:0] OP_SET_MAX_EXT  = 8'h37; // Set max address, extended

    ////////////////////////////////////////////////////////////////////////////
    // SMART feature codes
    localparam logic [7:0] SF_READ_DATA    = 8'hd0; // Send data structure
    localparam logic [7:0] SF_AUTOSAVE     = 8'hd2; // Auto-save control
    localparam logic [7:0] SF_OFFLINE      = 8'hd4; // Off-line execute
    localparam logic [7:0] SF_READ_LOG     = 8'hd5; // Send selected log
    localparam logic [7:0] SF_ENABLE       = 8'hd8; // Enable
    localparam logic [7:0] SF_DISABLE      = 8'hd9; // Disable
    localparam logic [7:0] SF_STATUS       = 8'hda; // Reliability status

    ////////////////////////////////////////////////////////////////////////////
    // Counts and reset values
    localparam logic [16:0] CNT_28_ZERO    = 17'h00100; // Zero count, 28-bit
    localparam logic [16:0] CNT_EXT_ZERO   = 17'h10000; // Zero count, extended
    localparam logic [7:0]  MULT_RST       = 8'h01;     // Block count after reset
    localparam logic [47:0] MAX_LBA_RST    = 48'h0000_0fff_ffff; // Plain default
    localparam int          LBA28_W        = 28;        // 28-bit address width

    ////////////////////////////////////////////////////////////////////////////
    // Taskfile carried with a command
    typedef struct packed {
        logic [7:0]  opcode;  // Command code
        logic [7:0]  feature; // Feature register
        logic [15:0] count;   // Sector count
        logic [47:0] lba;     // Start address
    } awsp_taskfile_t;

    // Completion status
    typedef struct packed {
        logic err;   // Error summary
        logic abrt;  // Command aborted
        logic idnf;  // Address out of range
    } awsp_status_t;

    // Sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_XFER = 2'b01,
        ST_DONE = 2'b10
    } awsp_state_t;

endpackage : awsp_pkg

// ===== verilog/awsp_cmd.sv
`timescale 1ns/100ps
module awsp_cmd (
    input  wire logic                    ref_clk_in,     // 25 MHz clock
    input  wire logic                    rst_b_in,       // Async reset, low
    input  wire logic                    cmd_valid_in,   // Command strobe
    input  wire awsp_pkg::awsp_taskfile_t cmd_in,        // Command taskfile
    input  wire logic                    xfer_done_in,   // Sector moved
    output logic                         busy_out,       // Busy
    output logic                         intrq_out,      // Interrupt pulse
    output awsp_pkg::awsp_status_t       status_out,     // Completion status
    output logic                         xfer_req_out,   // Sector request
    output logic [47:0]                  xfer_lba_out,   // Sector address
    output logic                         xfer_buf_out,   // Target is buffer
    output logic                         xfer_verify_out,// Verify sector
    output logic                         standby_out,    // Standby state
    output logic                         smart_en_out,   // SMART monitoring on
    output logic                         autosave_out,   // Attribute auto-save
    output logic [15:0]                  smart_evt_out,  // SMART event count
    output logic                         smart_req_out,  // SMART send pulse
    output logic [7:0]                   smart_kind_out, // Which SMART send
    output logic [7:0]                   smart_sel_out,  // Log or test select
    output logic                         offline_out,    // Off-line start pulse
    output logic [7:0]                   mult_out,       // Block count
    output logic [47:0]                  max_lba_out     // Max address
);

    ////////////////////////////////////////////////////////////////////////////
    // Effective sector count from the count field
    function automatic logic [16:0] eff_count(input logic ext, input logic [15:0] cnt);
        if (ext) begin
            eff_count = (cnt == 16'h0000) ? awsp_pkg::CNT_EXT_ZERO : {1'b0, cnt};
        end else begin
            eff_count = (cnt[7:0] == 8'h00) ? awsp_pkg::CNT_28_ZERO : {9'h000, cnt[7:0]};
        end
    endfunction : eff_count

    ////////////////////////////////////////////////////////////////////////////
    // State
    awsp_pkg::awsp_state_t state_reg;        // Sequencer state
    logic [16:0]           remain_reg;       // Sectors left
    logic [7:0]            blk_reg;          // Sectors in current block
    logic                  is_mult_reg;      // Multiple-block write
    logic                  is_dma_reg;       // Single final interrupt
    logic                  busy_reg;         // Busy
    logic                  intrq_reg;        // Interrupt pulse
    awsp_pkg::awsp_status_t status_reg;      // Status
    logic                  xfer_req_reg;     // Sector request
    logic [47:0]           lba_reg;          // Current sector
    logic                  buf_reg;          // Buffer target
    logic                  verify_reg;       // Verify each sector
    logic                  standby_reg;      // Standby
    logic                  smart_en_reg;     // SMART on
    logic                  autosave_reg;     // Auto-save on
    logic [15:0]           evt_reg;          // SMART event counter
    logic                  smart_req_reg;    // SMART send pulse
    logic [7:0]            kind_reg;         // SMART send kind
    logic [7:0]            sel_reg;          // Log or test select
    logic                  offline_reg;      // Off-line start pulse
    logic [7:0]            mult_reg;         // Block count
    logic [47:0]           max_reg;          // Max address

    ////////////////////////////////////////////////////////////////////////////
    // Decode
    wire [7:0]  op_w       = cmd_in.opcode;                        // Opcode
    wire [7:0]  ft_w       = cmd_in.feature;                       // Feature
    wire        accept_w   = cmd_valid_in && (state_reg == awsp_pkg::ST_IDLE); // Taken
    wire        op_w28_w   = (op_w == awsp_pkg::OP_WR_DMA_A) || (op_w == awsp_pkg::OP_WR_DMA_B)
                          || (op_w == awsp_pkg::OP_WR_PIO) || (op_w == awsp_pkg::OP_WR_NOERASE)
                          || (op_w == awsp_pkg::OP_WR_VERIFY) || (op_w == awsp_pkg::OP_WR_MULT);
    wire        op_wext_w  = (op_w == awsp_pkg::OP_WR_DMA_EXT) || (op_w == awsp_pkg::OP_WR_PIO_EXT)
                          || (op_w == awsp_pkg::OP_WR_MULT_EXT);
    wire        op_write_w = op_w28_w || op_wext_w;                 // Media write
    wire        op_mult_w  = (op_w == awsp_pkg::OP_WR_MULT) || (op_w == awsp_pkg::OP_WR_MULT_EXT);
    wire        op_dma_w   = (op_w == awsp_pkg::OP_WR_DMA_A) || (op_w == awsp_pkg::OP_WR_DMA_B)
                          || (op_w == awsp_pkg::OP_WR_DMA_EXT);
    wire        op_ver_w   = (op_w == awsp_pkg::OP_WR_VERIFY);
    wire        op_buf_w   = (op_w == awsp_pkg::OP_WR_BUFFER);
    wire        op_stby_w  = (op_w == awsp_pkg::OP_STANDBY) || (op_w == awsp_pkg::OP_STANDBY_IMM);
    wire        op_smart_w = (op_w == awsp_pkg::OP_SMART);
    wire        op_smul_w  = (op_w == awsp_pkg::OP_SET_MULT);
    wire        op_smax_w  = (op_w == awsp_pkg::OP_SET_MAX) || (op_w == awsp_pkg::OP_SET_MAX_EXT);
    wire        op_known_w = op_write_w || op_buf_w || op_stby_w || op_smart_w
                          || op_smul_w || op_smax_w;
    // SMART subfunction decode
    wire        sf_known_w = (ft_w == awsp_pkg::SF_READ_DATA) || (ft_w == awsp_pkg::SF_AUTOSAVE)
                          || (ft_w == awsp_pkg::SF_OFFLINE) || (ft_w == awsp_pkg::SF_READ_LOG)
                          || (ft_w == awsp_pkg::SF_ENABLE) || (ft_w == awsp_pkg::SF_DISABLE)
                          || (ft_w == awsp_pkg::SF_STATUS);
    wire        sf_ok_w    = smart_en_reg ? sf_known_w : (ft_w == awsp_pkg::SF_ENABLE);
    wire        sf_send_w  = (ft_w == awsp_pkg::SF_READ_DATA) || (ft_w == awsp_pkg::SF_READ_LOG)
                          || (ft_w == awsp_pkg::SF_STATUS);
    wire        abort_w    = !op_known_w || (op_smart_w && !sf_ok_w)
                          || (op_smul_w && (cmd_in.count[7:0] == 8'h00));
    // Address range check
    wire [47:0] lba_eff_w  = op_wext_w ? cmd_in.lba
                          : {20'h00000, cmd_in.lba[awsp_pkg::LBA28_W-1:0]};
    wire [16:0] cnt_w      = op_buf_w ? 17'h00001 : eff_count(op_wext_w, cmd_in.count);
    wire [48:0] last_w     = {1'b0, lba_eff_w} + {32'h00000000, cnt_w} - 49'h0_0000_0000_0001;
    wire        idnf_w     = op_write_w && (last_w > {1'b0, max_reg});
    wire        go_xfer_w  = accept_w && !abort_w && !idnf_w && (op_write_w || op_buf_w);
    wire        last_sec_w = (remain_reg == 17'h00001);               // Final sector
    wire [7:0]  blk_inc_w  = blk_reg + 8'h01;                         // Block position
    wire        blk_end_w  = is_mult_reg && (blk_inc_w == mult_reg);
    localparam int LBA28_PAD = 20;                                    // Pad above 28 bits

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer and transfer
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_reg    <= awsp_pkg::ST_IDLE;
            remain_reg   <= 17'h00000;
            blk_reg      <= 8'h00;
            is_mult_reg  <= 1'b0;
            is_dma_reg   <= 1'b0;
            busy_reg     <= 1'b0;
            intrq_reg    <= 1'b0;
            status_reg   <= '0;
            xfer_req_reg <= 1'b0;
            lba_reg      <= 48'h0000_0000_0000;
            buf_reg      <= 1'b0;
            verify_reg   <= 1'b0;
        end else begin
            intrq_reg <= 1'b0;
            unique case (state_reg)
                awsp_pkg::ST_IDLE: begin
                    if (accept_w) begin
                        busy_reg        <= 1'b1;
                        status_reg.abrt <= abort_w;
                        status_reg.idnf <= !abort_w && idnf_w;
                        status_reg.err  <= abort_w || idnf_w;
                        if (go_xfer_w) begin
                            state_reg    <= awsp_pkg::ST_XFER;
                            remain_reg   <= cnt_w;
                            lba_reg      <= lba_eff_w;
                            blk_reg      <= 8'h00;
                            is_mult_reg  <= op_mult_w;
                            is_dma_reg   <= op_dma_w || op_ver_w;
                            buf_reg      <= op_buf_w;
                            verify_reg   <= op_ver_w;
                            xfer_req_reg <= 1'b1;
                        end else begin
                            state_reg <= awsp_pkg::ST_DONE;
                        end
                    end
                end
                awsp_pkg::ST_XFER: begin
                    if (xfer_done_in) begin
                        remain_reg <= remain_reg - 17'h00001;
                        lba_reg    <= lba_reg + 48'h0000_0000_0001;
                        if (last_sec_w) begin
                            xfer_req_reg <= 1'b0;
                            state_reg    <= awsp_pkg::ST_DONE;
                        end else if (blk_end_w) begin
                            blk_reg   <= 8'h00;
                            intrq_reg <= 1'b1;
                        end else begin
                            blk_reg   <= blk_inc_w;
                            intrq_reg <= !is_mult_reg && !is_dma_reg;
                        end
                    end
                end
                awsp_pkg::ST_DONE: begin
                    busy_reg   <= 1'b0;
                    intrq_reg  <= 1'b1;
                    buf_reg    <= 1'b0;
                    verify_reg <= 1'b0;
                    state_reg  <= awsp_pkg::ST_IDLE;
                end
                default: begin
                    state_reg <= awsp_pkg::ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // SMART, power and configuration state
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            standby_reg   <= 1'b0;
            smart_en_reg  <= 1'b0;
            autosave_reg  <= 1'b0;
            evt_reg       <= 16'h0000;
            smart_req_reg <= 1'b0;
            kind_reg      <= 8'h00;
            sel_reg       <= 8'h00;
            offline_reg   <= 1'b0;
            mult_reg      <= awsp_pkg::MULT_RST;
            max_reg       <= awsp_pkg::MAX_LBA_RST;
        end else begin
            smart_req_reg <= 1'b0;
            offline_reg   <= 1'b0;
            if (smart_en_reg && (state_reg == awsp_pkg::ST_XFER) && xfer_done_in) begin
                evt_reg <= evt_reg + 16'h0001;
            end
            if (accept_w && !abort_w) begin
                if (op_stby_w) begin
                    standby_reg <= 1'b1;
                end
                if (go_xfer_w) begin
                    standby_reg <= 1'b0;
                end
                if (op_smul_w) begin
                    mult_reg <= cmd_in.count[7:0];
                end
                if (op_smax_w) begin
                    max_reg <= (op_w == awsp_pkg::OP_SET_MAX_EXT) ? cmd_in.lba
                             : {LBA28_PAD'(0), cmd_in.lba[awsp_pkg::LBA28_W-1:0]};
                end
                if (op_smart_w) begin
                    unique case (ft_w)
                        awsp_pkg::SF_ENABLE: begin
                            smart_en_reg <= 1'b1;
                        end
                        awsp_pkg::SF_DISABLE: begin
                            smart_en_reg <= 1'b0;
                            autosave_reg <= 1'b0;
                            evt_reg      <= 16'h0000;
                        end
                        awsp_pkg::SF_AUTOSAVE: begin
                            autosave_reg <= (cmd_in.count[7:0] != 8'h00);
                        end
                        awsp_pkg::SF_OFFLINE: begin
                            offline_reg <= 1'b1;
                            sel_reg     <= cmd_in.lba[7:0];
                        end
                        default: begin
                            smart_req_reg <= sf_send_w;
                            kind_reg      <= ft_w;
                            sel_reg       <= cmd_in.lba[7:0];
                        end
                    endcase
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign busy_out        = busy_reg;
    assign intrq_out       = intrq_reg;
    assign status_out      = status_reg;
    assign xfer_req_out    = xfer_req_reg;
    assign xfer_lba_out    = lba_reg;
    assign xfer_buf_out    = buf_reg;
    assign xfer_verify_out = verify_reg;
    assign standby_out     = standby_reg;
    assign smart_en_out    = smart_en_reg;
    assign autosave_out    = autosave_reg;
    assign smart_evt_out   = evt_reg;
    assign smart_req_out   = smart_req_reg;
    assign smart_kind_out  = kind_reg;
    assign smart_sel_out   = sel_reg;
    assign offline_out     = offline_reg;
    assign mult_out        = mult_reg;
    assign max_lba_out     = max_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_b_in);

    // Completion: busy falls with the interrupt
    sequence seq_complete;
        !busy_out && intrq_out;
    endsequence

    // Standby entry
    sequence seq_standby;
        busy_out && standby_out ##1 seq_complete;
    endsequence

    AST_STANDBY: assert property (accept_w && op_stby_w |=> seq_standby)
        else $error("standby sequence wrong");

    AST_SMART_OFF_ABORT: assert property (accept_w && op_smart_w && !smart_en_out
            && (ft_w != awsp_pkg::SF_ENABLE) |=> busy_out ##1 (seq_complete
            and (status_out.abrt && !smart_en_out)))
        else $error("disabled SMART not aborted");

    AST_UNKNOWN_ABORT: assert property (accept_w && !op_known_w
            |=> ##1 (intrq_out && status_out.abrt && status_out.err))
        else $error("unknown opcode not aborted");

    AST_ENABLE: assert property (accept_w && op_smart_w && (ft_w == awsp_pkg::SF_ENABLE)
            |=> smart_en_out && !status_out.err)
        else $error("SMART enable failed");

    AST_DISABLE: assert property (accept_w && op_smart_w && smart_en_out
            && (ft_w == awsp_pkg::SF_DISABLE)
            |=> !smart_en_out && !autosave_out && (smart_evt_out == 16'h0000))
        else $error("SMART disable left state");

    AST_NO_MON: assert property (!smart_en_out |=> $stable(smart_evt_out)
            || (smart_evt_out == 16'h0000))
        else $error("SMART counting while disabled");

    AST_COUNT28: assert property (go_xfer_w && op_w28_w && (cmd_in.count[7:0] == 8'h00)
            |=> remain_reg == awsp_pkg::CNT_28_ZERO)
        else $error("28-bit zero count wrong");

    AST_COUNTEXT: assert property (go_xfer_w && op_wext_w && (cmd_in.count == 16'h0000)
            |=> remain_reg == awsp_pkg::CNT_EXT_ZERO)
        else $error("extended zero count wrong");

    AST_START_LBA: assert property (go_xfer_w
            |=> xfer_req_out && (xfer_lba_out == $past(lba_eff_w)))
        else $error("transfer start address wrong");

    AST_IDNF: assert property (accept_w && !abort_w && idnf_w
            |=> ##1 (intrq_out && status_out.idnf && !xfer_req_out))
        else $error("range error not reported");

    AST_MULT_IRQ: assert property ((state_reg == awsp_pkg::ST_XFER) && xfer_done_in
            && is_mult_reg && !last_sec_w |=> intrq_out == $past(blk_end_w))
        else $error("block interrupt misplaced");

    AST_OFFLINE: assert property (accept_w && op_smart_w && smart_en_out
            && (ft_w == awsp_pkg::SF_OFFLINE) |=> offline_out && busy_out)
        else $error("off-line start missing");

endmodule : awsp_cmd
